// [rtl/udmc_top.sv]
// interrupt enable mask, dma configuration and dma counter behind the command port
`timescale 1ns/1ps
`default_nettype none
module udmc_top
  import udmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire udmc_port_t port,
  input wire logic usb_bus_reset,
  input wire udmc_events_t events,
  input wire logic event_clear,
  input wire logic dma_byte_done,
  input wire logic short_packet_out,
  output logic [7:0] rd_data,
  output logic [31:0] interrupt_mask,
  output logic [15:0] dma_configuration,
  output logic [15:0] dma_byte_counter,
  output logic [15:0] dma_remaining,
  output logic [31:0] irq_sources,
  output logic irq_request,
  output logic dma_run,
  output logic [3:0] dma_endpoint_select,
  output logic [4:0] dma_burst_bytes,
  output logic transfer_end_condition,
  output logic device_reset
);
  typedef enum {UDMC_IDLE, UDMC_MASK, UDMC_CFG, UDMC_CNT} udmc_state_t;

  udmc_state_t state;
  logic rd_phase;
  logic [2:0] byte_idx;
  logic soft_rst;
  logic run_set;
  logic cnt_zero;
  logic short_end;
  logic [31:0] next_mask;
  logic [15:0] next_cfg;
  logic [15:0] next_cnt;

  // burst field decode, used for the dma_burst_bytes output
  function automatic logic [4:0] burst_len(input logic [1:0] code);
    case (code)
      2'h0: burst_len = BURST_1;
      2'h1: burst_len = BURST_4;
      2'h2: burst_len = BURST_8;
      default: burst_len = BURST_16;
    endcase
  endfunction : burst_len

  // replace byte k of a word, low byte first on the port
  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [2:0] k,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[k[1:0]*8 +: 8] = b;
    put_byte = r;
  endfunction : put_byte

  // soft reset takes one clock, then mask, configuration, counters and sources are at reset value; rd_data keeps its value
  always_comb soft_rst = port.cmd_wr && port.data == CMD_DEV_RESET; // RULE17
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      device_reset <= 1'b0;
    else
      device_reset <= soft_rst;
  end

  // command decoder; a new command aborts any unfinished data phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= UDMC_IDLE;
      rd_phase <= 1'b0;
      byte_idx <= 3'h0;
    end
    else if (port.cmd_wr)
    begin
      byte_idx <= 3'h0;
      if (port.data == CMD_MASK_WR || port.data == CMD_MASK_RD) // RULE18
        state <= UDMC_MASK;
      else if (port.data == CMD_CFG_WR || port.data == CMD_CFG_RD) // RULE6
        state <= UDMC_CFG;
      else if (port.data == CMD_CNT_WR || port.data == CMD_CNT_RD) // RULE13
        state <= UDMC_CNT;
      else
        state <= UDMC_IDLE;
      rd_phase <= port.data[0];
    end
    else if (port.data_wr || port.data_rd)
    begin
      case (state)
        UDMC_MASK:
          if (byte_idx == MASK_BYTES - 3'h1)
            state <= UDMC_IDLE;
        UDMC_CFG:
          if (byte_idx == CFG_BYTES - 3'h1)
            state <= UDMC_IDLE;
        UDMC_CNT:
          if (byte_idx == CNT_BYTES - 3'h1)
            state <= UDMC_IDLE;
        default:
          state <= UDMC_IDLE;
      endcase
      byte_idx <= byte_idx + 3'h1;
    end
  end

  // write data assembled byte by byte; register updates with every byte
  always_comb
  begin
    next_mask = put_byte(interrupt_mask, byte_idx, port.data) & MASK_WRITABLE; // RULE5
    next_cfg = 16'(put_byte({16'h0000, dma_configuration}, byte_idx, port.data)
               & {16'h0000, CFG_WRITABLE});
    next_cnt = 16'(put_byte({16'h0000, dma_byte_counter}, byte_idx, port.data)); // RULE15
  end

  // mask is untouched by bus reset; partial bytes land as they arrive
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      interrupt_mask <= MASK_RESET;
    else if (soft_rst)
      interrupt_mask <= MASK_RESET; // RULE17
    else if (state == UDMC_MASK && !rd_phase && port.data_wr && !port.cmd_wr)
      interrupt_mask <= next_mask; // RULE18
  end

  // first config byte written with the run bit set reloads the down counter
  always_comb run_set = state == UDMC_CFG && !rd_phase && port.data_wr && !port.cmd_wr
                        && byte_idx == 3'h0 && port.data[CFG_RUN]; // RULE14

  // configuration: bus reset drops only the run bit, end conditions stop dma
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dma_configuration <= CFG_RESET;
    else if (soft_rst)
      dma_configuration <= CFG_RESET; // RULE17
    else if (usb_bus_reset)
      dma_configuration[CFG_RUN] <= 1'b0; // RULE7
    else if (state == UDMC_CFG && !rd_phase && port.data_wr && !port.cmd_wr)
      dma_configuration <= next_cfg[15:0]; // RULE11
    else if (transfer_end_condition)
      dma_configuration[CFG_RUN] <= 1'b0; // RULE11
  end

  // programmed count, kept over bus reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dma_byte_counter <= CNT_RESET;
    else if (soft_rst)
      dma_byte_counter <= CNT_RESET; // RULE17
    else if (state == UDMC_CNT && !rd_phase && port.data_wr && !port.cmd_wr)
      dma_byte_counter <= next_cnt[15:0]; // RULE16
  end

  udmc_counter #(.WIDTH(16)) u_counter (
    .clk(clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .reload(run_set),
    .reload_value(dma_byte_counter),
    .run(dma_run),
    .byte_done(dma_byte_done),
    .remaining(dma_remaining),
    .hit_zero(cnt_zero)
  );

  // live configuration fields
  always_comb
  begin
    dma_run = dma_configuration[CFG_RUN]; // RULE11
    dma_endpoint_select = dma_configuration[CFG_EP_LO +: 4]; // RULE10
    dma_burst_bytes = burst_len(dma_configuration[CFG_BURST_LO +: 2]); // RULE12
    short_end = dma_run && dma_configuration[CFG_SHORT_END] && short_packet_out; // RULE9
  end

  // end of transfer from counter or short packet, one cycle pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      transfer_end_condition <= 1'b0;
    else
      transfer_end_condition <= !soft_rst && !usb_bus_reset && !transfer_end_condition
        && ((cnt_zero && dma_configuration[CFG_CNT_END]) || short_end); // RULE8
  end

  // sticky sources record every event; set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_sources <= 32'h00000000;
    else if (soft_rst)
      irq_sources <= 32'h00000000;
    else if (event_clear)
      irq_sources <= events & MASK_WRITABLE; // RULE19
    else
      irq_sources <= irq_sources | (events & MASK_WRITABLE); // RULE19
  end

  // only the request line depends on the mask
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_request <= 1'b0;
    else
      irq_request <= |(irq_sources & interrupt_mask); // RULE1 RULE2 RULE3 RULE4
  end

  // read data: counter read returns bytes still to move
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data <= 8'h00;
    else if (rd_phase && port.data_rd && !port.cmd_wr)
    begin
      if (state == UDMC_MASK)
        rd_data <= interrupt_mask[byte_idx[1:0]*8 +: 8];
      else if (state == UDMC_CFG)
        rd_data <= dma_configuration[byte_idx[0]*8 +: 8];
      else if (state == UDMC_CNT)
        rd_data <= dma_remaining[byte_idx[0]*8 +: 8]; // RULE13
      else
        rd_data <= 8'h00;
    end
  end

  // assertions
  sequence s_cfg_write_run;
    state == UDMC_CFG && !rd_phase && port.data_wr && !port.cmd_wr && byte_idx == 3'h0
      && port.data[CFG_RUN];
  endsequence

  a_bus_reset_run: assert property (@(posedge clk) disable iff (rst)
    usb_bus_reset && !soft_rst |=> !dma_run) else $error("run survived bus reset"); // RULE7
  a_bus_reset_keep: assert property (@(posedge clk) disable iff (rst)
    usb_bus_reset && !soft_rst |=> $stable(dma_configuration[15:4]) && $stable(dma_byte_counter)
      && $stable(interrupt_mask)) else $error("bus reset changed fields"); // RULE16
  a_run_reload: assert property (@(posedge clk) disable iff (rst)
    s_cfg_write_run |=> dma_remaining == $past(dma_byte_counter))
    else $error("counter not reloaded"); // RULE14
  a_soft_reset_all: assert property (@(posedge clk) disable iff (rst)
    soft_rst |=> interrupt_mask == MASK_RESET && dma_configuration == CFG_RESET
      && dma_byte_counter == CNT_RESET && device_reset) else $error("soft reset missed"); // RULE17
  a_count_end: assert property (@(posedge clk) disable iff (rst)
    cnt_zero && dma_configuration[CFG_CNT_END] && !soft_rst && !usb_bus_reset
      && !transfer_end_condition |=> transfer_end_condition ##1 !dma_run)
    else $error("no end at count zero"); // RULE8
  a_short_end: assert property (@(posedge clk) disable iff (rst)
    short_end && !soft_rst && !usb_bus_reset && !transfer_end_condition
      |=> transfer_end_condition) else $error("no end on short packet"); // RULE9
  a_mask_gate: assert property (@(posedge clk) disable iff (rst)
    (irq_sources & interrupt_mask) == 32'h00000000 |=> !irq_request)
    else $error("masked event raised request"); // RULE1
  a_burst_map: assert property (@(posedge clk) disable iff (rst)
    dma_configuration[1:0] == 2'h3 |-> dma_burst_bytes == BURST_16)
    else $error("burst decode wrong"); // RULE12
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    interrupt_mask[31:24] == 8'h00 && dma_configuration[13:8] == 6'h00)
    else $error("reserved bits set"); // RULE5
  a_event_kept: assert property (@(posedge clk) disable iff (rst)
    events.pseudo_frame && !soft_rst |=> irq_sources[MASK_PSOF])
    else $error("event lost"); // RULE19
endmodule : udmc_top
`default_nettype wire

// [inc/udmc_pkg.sv]
// package with command codes, field layouts and reset values of the mask and dma control block
//
// Contract
// RULE1: mask bits 23..10 enable interrupts of data endpoints 1 to 14.
// RULE2: bit 9 gates control IN, bit 8 gates control OUT interrupts.
// RULE3: bit 5 enables the 1 ms pseudo frame start interrupt.
// RULE4: bits 4..0 enable frame start, transfer end, suspend, resume, bus reset.
// RULE5: software writes zeros into mask bits 31..24.
// RULE6: dma configuration written by F0, read by F1, two data bytes each.
// RULE7: bus reset clears dma run bit only; hardware reset zeroes all.
// RULE8: bit 15 set makes counter reaching zero end the transfer.
// RULE9: bit 14 set makes a short OUT packet end the transfer.
// RULE10: bits 7..4 select the endpoint buffer used by dma.
// RULE11: run bit starts dma, clearing it stops at once, reads live state.
// RULE12: burst field 00,01,10,11 gives 1, 4, 8, 16 byte bursts.
// RULE13: counter written by F2, read by F3; read gives bytes remaining.
// RULE14: setting the run bit reloads the internal down counter.
// RULE15: counter high byte in bits 15..8, low byte in bits 7..0.
// RULE16: bus reset leaves the programmed counter unchanged.
// RULE17: command F6 resets every register like the hardware reset; the code leaves rd_data at its value.
// RULE18: mask written by C2, read by C3, four bytes, kept over bus reset.
// RULE19: masked events still recorded; only the interrupt output is gated.
package udmc_pkg;
  localparam logic [7:0] CMD_MASK_WR = 8'hC2;
  localparam logic [7:0] CMD_MASK_RD = 8'hC3;
  localparam logic [7:0] CMD_CFG_WR = 8'hF0;
  localparam logic [7:0] CMD_CFG_RD = 8'hF1;
  localparam logic [7:0] CMD_CNT_WR = 8'hF2;
  localparam logic [7:0] CMD_CNT_RD = 8'hF3;
  localparam logic [7:0] CMD_DEV_RESET = 8'hF6;
  localparam logic [2:0] MASK_BYTES = 3'h4;
  localparam logic [2:0] CFG_BYTES = 3'h2;
  localparam logic [2:0] CNT_BYTES = 3'h2;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [31:0] MASK_WRITABLE = 32'h00FFFF3F;
  localparam logic [15:0] CFG_WRITABLE = 16'hC0FB;
  localparam int MASK_EP_LO = 10;
  localparam int MASK_EP_HI = 23;
  localparam int MASK_CTRL_IN = 9;
  localparam int MASK_CTRL_OUT = 8;
  localparam int MASK_PSOF = 5;
  localparam int MASK_SOF = 4;
  localparam int MASK_EOT = 3;
  localparam int MASK_SUSP = 2;
  localparam int MASK_RESM = 1;
  localparam int MASK_BRST = 0;
  localparam int CFG_CNT_END = 15;
  localparam int CFG_SHORT_END = 14;
  localparam int CFG_EP_LO = 4;
  localparam int CFG_RUN = 3;
  localparam int CFG_BURST_LO = 0;
  localparam logic [4:0] BURST_1 = 5'h01;
  localparam logic [4:0] BURST_4 = 5'h04;
  localparam logic [4:0] BURST_8 = 5'h08;
  localparam logic [4:0] BURST_16 = 5'h10;
  // event sources in mask bit order (bits 7,6 never set)
  typedef struct packed {
    logic [13:0] endpoint;
    logic ctrl_in;
    logic ctrl_out;
    logic [1:0] unused;
    logic pseudo_frame;
    logic frame_start;
    logic transfer_end;
    logic suspend;
    logic resume;
    logic bus_reset;
  } udmc_events_t;
  // command port request
  typedef struct packed {
    logic cmd_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] data;
  } udmc_port_t;
endpackage : udmc_pkg

// [rtl/udmc_counter.sv]
// dma byte down counter with reload and zero detect
`timescale 1ns/1ps
`default_nettype none
module udmc_counter
  import udmc_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic reload,
  input wire logic [WIDTH-1:0] reload_value,
  input wire logic run,
  input wire logic byte_done,
  output logic [WIDTH-1:0] remaining,
  output logic hit_zero
);
  // reload wins over a byte moved in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      remaining <= '0;
    else if (soft_rst)
      remaining <= '0;
    else if (reload) // RULE14
      remaining <= reload_value;
    else if (run && byte_done && remaining != '0)
      remaining <= remaining - WIDTH'(1);
  end

  // one pulse when the last byte leaves the counter
  always_comb hit_zero = run && !reload && byte_done && remaining == WIDTH'(1); // RULE8
endmodule : udmc_counter
`default_nettype wire

// [testbench/udmc_dma_model.sv]
// dma controller model that moves one byte every gap+1 cycles while dma runs
`timescale 1ns/1ps
`default_nettype none
module udmc_dma_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] gap,
  output logic byte_done
);
  logic [7:0] wait_cnt;
  // one byte every gap+1 cycles; a large gap models a stalled controller
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_cnt <= 8'h00;
      byte_done <= 1'b0;
    end
    else
    begin
      byte_done <= run && (wait_cnt == gap);
      wait_cnt <= (!run || wait_cnt == gap) ? 8'h00 : wait_cnt + 8'h01;
    end
  end
endmodule : udmc_dma_model
`default_nettype wire

// [testbench/test_udmc_top.sv]
// self-checking bench of the mask and dma control block
`timescale 1ns/1ps
`default_nettype none
module test_udmc_top;
  import udmc_pkg::*;
  logic clk, rst, usb_bus_reset, event_clear, short_packet_out, byte_done;
  udmc_port_t port;
  udmc_events_t events;
  logic [7:0] rd_data, gap;
  logic [31:0] interrupt_mask, irq_sources, v;
  logic [15:0] dma_configuration, dma_byte_counter, dma_remaining;
  logic irq_request, dma_run, transfer_end_condition, device_reset;
  logic [3:0] dma_endpoint_select;
  logic [4:0] dma_burst_bytes;
  int errors, n_tests;

  udmc_top i_dut (.clk, .rst, .port, .usb_bus_reset, .events, .event_clear,
    .dma_byte_done(byte_done), .short_packet_out, .rd_data, .interrupt_mask,
    .dma_configuration, .dma_byte_counter, .dma_remaining, .irq_sources,
    .irq_request, .dma_run, .dma_endpoint_select, .dma_burst_bytes,
    .transfer_end_condition, .device_reset);
  udmc_dma_model i_dma (.clk, .rst, .run(dma_run), .gap, .byte_done);

  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    #1;
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    #1;
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // one strobe then an idle cycle, so no strobe is raised twice at one edge;
  // returns just past the taking edge so later checks see settled outputs
  task automatic strobe(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    port <= {s, d};
    @(posedge clk);
    port <= '0;
    #1;
  endtask : strobe

  task automatic wr(input logic [7:0] c, input logic [31:0] d, input int n);
    strobe(3'h4, c);
    for (int i = 0; i < n; i++)
      strobe(3'h2, d[8*i+:8]);
  endtask : wr

  task automatic rd(input logic [7:0] c, input int n, output logic [31:0] d);
    d = '0;
    strobe(3'h4, c);
    for (int i = 0; i < n; i++)
    begin
      strobe(3'h1, 8'h00);
      #1;
      d[8*i+:8] = rd_data;
    end
  endtask : rd

  // the end pulse lasts one cycle, so poll it at every edge
  task automatic wait_end(input int lim);
    for (int k = 0; k < lim; k++)
    begin
      @(posedge clk);
      #1;
      if (transfer_end_condition)
        break;
    end
  endtask : wait_end

  task automatic t_reset_values();
    rd(CMD_MASK_RD, 4, v);
    chk_val(v, 32'h00000000);
    rd(CMD_CFG_RD, 2, v);
    chk_val(v, 32'h00000000);
    rd(CMD_CNT_RD, 2, v);
    chk_val(v, 32'h00000000);
  endtask : t_reset_values

  // each source is recorded while masked and reaches the request once enabled
  task automatic t_mask_events();
    for (int i = 0; i < 24; i++)
    begin
      if (i == 6 || i == 7)
        continue;
      wr(CMD_MASK_WR, 32'h00000000, 4);
      @(posedge clk);
      events <= udmc_events_t'(32'h1 << i);
      @(posedge clk);
      events <= '0;
      repeat (3) @(posedge clk);
      chk_bit(irq_sources[i], 1'b1);
      chk_bit(irq_request, 1'b0);
      wr(CMD_MASK_WR, 32'h1 << i, 4);
      repeat (2) @(posedge clk);
      chk_bit(irq_request, 1'b1);
      @(posedge clk);
      event_clear <= 1'b1;
      @(posedge clk);
      event_clear <= 1'b0;
      repeat (2) @(posedge clk);
      chk_bit(irq_request, 1'b0);
    end
    rd(CMD_MASK_RD, 4, v);
    chk_val(v, 32'h00800000);
  endtask : t_mask_events

  task automatic t_dma_count();
    gap <= 8'h14;
    wr(CMD_CNT_WR, 32'h00000005, 2);
    chk_val(dma_byte_counter, 32'h00000005);
    wr(CMD_CFG_WR, 32'h000080A9, 2);
    chk_bit(dma_run, 1'b1);
    chk_val(dma_endpoint_select, 32'h0000000A);
    rd(CMD_CNT_RD, 2, v);
    chk_val(v, 32'h00000005);
    wait_end(300);
    chk_bit(transfer_end_condition, 1'b1);
    chk_val(dma_remaining, 32'h00000000);
    repeat (2) @(posedge clk);
    chk_bit(dma_run, 1'b0);
    wr(CMD_CFG_WR, 32'h000080A9, 2);
    chk_val(dma_remaining, 32'h00000005);
    wr(CMD_CFG_WR, 32'h000080A1, 2);
    chk_bit(dma_run, 1'b0);
  endtask : t_dma_count

  // every burst code, with reserved bits written as ones
  task automatic t_burst();
    logic [4:0] exp [4] = '{BURST_1, BURST_4, BURST_8, BURST_16};
    for (int b = 0; b < 4; b++)
    begin
      wr(CMD_CFG_WR, {16'h0000, 8'hFF, 4'(b * 5), 4'h4 | 4'(b)}, 2);
      chk_val(dma_burst_bytes, exp[b]);
      chk_val(dma_configuration, {8'hC0, 4'(b * 5), 2'h0, 2'(b)});
    end
  endtask : t_burst

  task automatic t_short_packet();
    gap <= 8'hFF;
    wr(CMD_CFG_WR, 32'h00004008, 2);
    @(posedge clk);
    short_packet_out <= 1'b1;
    @(posedge clk);
    short_packet_out <= 1'b0;
    // the one-cycle end pulse rises at the edge that takes the short packet
    #1;
    chk_bit(transfer_end_condition, 1'b1);
  endtask : t_short_packet

  task automatic t_bus_reset();
    wr(CMD_MASK_WR, 32'h00ABCD3F, 4);
    wr(CMD_CNT_WR, 32'h00001234, 2);
    wr(CMD_CFG_WR, 32'h000080F9, 2);
    @(posedge clk);
    usb_bus_reset <= 1'b1;
    @(posedge clk);
    usb_bus_reset <= 1'b0;
    #1;
    chk_bit(dma_run, 1'b0);
    chk_val(dma_configuration, 32'h000080F1);
    chk_val(dma_byte_counter, 32'h00001234);
    chk_val(interrupt_mask, 32'h00ABCD3F);
  endtask : t_bus_reset

  task automatic t_soft_reset();
    logic seen;
    seen = 1'b0;
    strobe(3'h4, CMD_DEV_RESET);
    for (int k = 0; k < 4; k++)
    begin
      #1;
      if (device_reset)
        seen = 1'b1;
      @(posedge clk);
    end
    chk_bit(seen, 1'b1);
    chk_val(interrupt_mask, 32'h00000000);
    chk_val(dma_configuration, 32'h00000000);
    chk_val(dma_byte_counter, 32'h00000000);
  endtask : t_soft_reset

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial
  begin
    rst = 1'b1;
    port = '0;
    events = '0;
    usb_bus_reset = 1'b0;
    event_clear = 1'b0;
    short_packet_out = 1'b0;
    gap = 8'h00;
    errors = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_mask_events();
    t_dma_count();
    t_burst();
    t_short_packet();
    t_bus_reset();
    t_soft_reset();
    report_and_stop();
  end

  // watchdog well above the roughly one thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule : test_udmc_top
`default_nettype wire
